//--- rtl/vxd_pkg.sv
// vxd_pkg: constants and carrier types for the register window decoder
// assumes a 16-bit backplane address and 16-bit data path
package vxd_pkg;

  localparam int          ADDR_W        = 16;
  localparam int          DATA_W        = 16;
  localparam int          LA_W          = 8;
  localparam int          OFFS_W        = 6;
  localparam logic [15:0] REGION_BASE   = 16'hC000;
  localparam logic [1:0]  REGION_TOP    = 2'h3;
  localparam logic [7:0]  LA_RESET      = 8'h18;
  localparam int          BLOCK_BYTES   = 64;
  localparam int          REG_COUNT     = 7;

  localparam logic [5:0]  OFS_ID        = 6'h00;
  localparam logic [5:0]  OFS_DEVTYPE   = 6'h02;
  localparam logic [5:0]  OFS_STATCTL   = 6'h04;
  localparam logic [5:0]  OFS_CMD       = 6'h08;
  localparam logic [5:0]  OFS_PARM      = 6'h0A;
  localparam logic [5:0]  OFS_DATA      = 6'h0C;
  localparam logic [5:0]  OFS_DATA_LO   = 6'h0E;

  localparam logic [15:0] ID_VALUE      = 16'hF123; // arbitrary value
  localparam logic [15:0] DEVTYPE_VALUE = 16'h0A5A; // arbitrary value
  localparam logic [7:0]  STAT_HI       = 8'hFF;
  localparam logic [15:0] CMD_RESET     = 16'h0000;

  typedef enum logic [2:0] {
    VXD_SEL_NONE,
    VXD_SEL_ID,
    VXD_SEL_DEVTYPE,
    VXD_SEL_STATCTL,
    VXD_SEL_CMD,
    VXD_SEL_PARM,
    VXD_SEL_DATA,
    VXD_SEL_DATA_LO
  } vxd_sel_t;

  typedef struct packed {
    logic        strobe;
    logic        write;
    logic        word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } vxd_req_t;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } vxd_rsp_t;

endpackage : vxd_pkg

//--- rtl/vxd_opcode_store.sv
// vxd_opcode_store: two-word holding store for command and parameter
// assumes writes and reads in the same clock domain, read data registered
`timescale 1ns/1ns
`default_nettype none
module vxd_opcode_store #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             ce_i,
  input  wire logic             we_i,
  input  wire logic             waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic [WIDTH-1:0] wmask_i,
  input  wire logic             raddr_i,
  output logic      [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem_reg [2];
  logic [WIDTH-1:0] mem_next [2];
  logic [WIDTH-1:0] rdata_next;

  // byte lane merge needs at least one whole byte
  if (WIDTH < 8) begin : g_bad_width
    $error("store width below one byte");
  end

  // merge byte lanes so byte writes keep the other lane
  always_comb begin
    mem_next = mem_reg;
    if (we_i) begin
      mem_next[waddr_i] = (mem_reg[waddr_i] & ~wmask_i) |
                          (wdata_i & wmask_i);
    end
    rdata_next = mem_reg[raddr_i];
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      rdata_o    <= '0;
    end else if (ce_i) begin
      mem_reg <= mem_next;
      rdata_o <= rdata_next;
    end
  end

endmodule : vxd_opcode_store
`default_nettype wire

//--- rtl/vxd_reg_window.sv
// vxd_reg_window: claims one 64-byte register block in the top quarter
// of the 16-bit backplane space and routes byte or word accesses to it.
// assumes bus inputs synchronous to REF_CLK_I, one strobe per access.
//
// What this block does
// - claim accesses only when the top two address bits are both one
// - each module owns one 64-byte block; up to 256 logical addresses
// - block base equals C000 plus logical address times 64
// - register chosen by low six address bits, offset within block
// - command opcode register accepted at byte offset 08
// - logical address defaults to 24, base C600, unless changed
// - only seven register offsets respond; the rest hold nothing
// - both 8-bit byte and 16-bit word accesses answer correctly
// - plain register access only; no word-serial message protocol
`timescale 1ns/1ns
`default_nettype none
module vxd_reg_window #(
  parameter logic [7:0] LA_DEFAULT = vxd_pkg::LA_RESET
) (
  input  wire logic                REF_CLK_I,
  input  wire logic                RST_B_I,
  input  wire logic                CE_I,
  input  wire logic                LA_LOAD_I,
  input  wire logic [7:0]          LA_VALUE_I,
  input  wire vxd_pkg::vxd_req_t   BUS_REQ_I,
  input  wire logic [15:0]         STATUS_I,
  input  wire logic [15:0]         DATA_I,
  output var vxd_pkg::vxd_rsp_t    BUS_RSP_O,
  output logic [2:0]               CONTROL_O,
  output logic [15:0]              CMD_OPCODE_O,
  output logic                     CMD_STROBE_O,
  output logic [15:0]              PARM_OPCODE_O,
  output logic                     PARM_STROBE_O,
  output logic [7:0]               LA_O
);

  // offset decode assumes one block spans exactly the offset field
  if (vxd_pkg::BLOCK_BYTES != (1 << vxd_pkg::OFFS_W)) begin : g_bad_block
    $error("block size must match the offset width");
  end

  ////////////////////////////////////////////////////////////////////////
  // address decode

  // base of the block for a logical address
  function automatic logic [15:0] block_base(input logic [7:0] la);
    block_base = vxd_pkg::REGION_BASE | {2'h0, la, 6'h00};
  endfunction : block_base

  // register select from the offset; odd addresses name the low lane
  function automatic vxd_pkg::vxd_sel_t offs_sel(input logic [5:0] ofs);
    case ({ofs[5:1], 1'b0})
      vxd_pkg::OFS_ID:      offs_sel = vxd_pkg::VXD_SEL_ID;
      vxd_pkg::OFS_DEVTYPE: offs_sel = vxd_pkg::VXD_SEL_DEVTYPE;
      vxd_pkg::OFS_STATCTL: offs_sel = vxd_pkg::VXD_SEL_STATCTL;
      vxd_pkg::OFS_CMD:     offs_sel = vxd_pkg::VXD_SEL_CMD;
      vxd_pkg::OFS_PARM:    offs_sel = vxd_pkg::VXD_SEL_PARM;
      vxd_pkg::OFS_DATA:    offs_sel = vxd_pkg::VXD_SEL_DATA;
      vxd_pkg::OFS_DATA_LO: offs_sel = vxd_pkg::VXD_SEL_DATA_LO;
      default:              offs_sel = vxd_pkg::VXD_SEL_NONE;
    endcase
  endfunction : offs_sel

  logic [7:0]        la_reg;
  logic [7:0]        la_next;
  logic              in_region;
  logic              in_block;
  vxd_pkg::vxd_sel_t sel;
  logic              hit;
  logic [15:0]       lane_mask;
  logic [15:0]       blk_base;

  // top quarter check, then base compare on the upper ten bits
  always_comb begin
    blk_base  = block_base(la_reg);
    in_region = (BUS_REQ_I.addr[15:14] == vxd_pkg::REGION_TOP);
    in_block  = in_region &&
                (BUS_REQ_I.addr[15:6] == blk_base[15:6]);
    sel       = offs_sel(BUS_REQ_I.addr[5:0]);
    hit       = BUS_REQ_I.strobe && in_block &&
                (sel != vxd_pkg::VXD_SEL_NONE);
    // word uses both lanes; even byte is upper lane, odd byte lower
    if (BUS_REQ_I.word) lane_mask = 16'hFFFF;
    else if (BUS_REQ_I.addr[0]) lane_mask = 16'h00FF;
    else lane_mask = 16'hFF00;
  end

  ////////////////////////////////////////////////////////////////////////
  // logical address selection, reset value is the factory default

  always_comb begin
    la_next = la_reg;
    if (LA_LOAD_I) la_next = LA_VALUE_I;
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) la_reg <= LA_DEFAULT;
    else if (CE_I) la_reg <= la_next;
  end

  assign LA_O = la_reg;

  ////////////////////////////////////////////////////////////////////////
  // write side: control bits and opcode strobes

  logic [2:0]  ctl_reg;
  logic [2:0]  ctl_next;
  logic        cmd_stb_reg;
  logic        cmd_stb_next;
  logic        parm_stb_reg;
  logic        parm_stb_next;
  logic        wr_hit;
  logic        st_we;
  logic        st_waddr;

  // registers are written directly; there is no serial message engine
  always_comb begin
    wr_hit        = hit && BUS_REQ_I.write;
    ctl_next      = ctl_reg;
    cmd_stb_next  = 1'b0;
    parm_stb_next = 1'b0;
    st_we         = 1'b0;
    st_waddr      = 1'b0;
    if (wr_hit) begin
      case (sel)
        vxd_pkg::VXD_SEL_STATCTL: begin
          if (lane_mask[0]) ctl_next = BUS_REQ_I.wdata[2:0];
        end
        vxd_pkg::VXD_SEL_CMD: begin
          st_we        = 1'b1;
          cmd_stb_next = 1'b1;
        end
        vxd_pkg::VXD_SEL_PARM: begin
          st_we         = 1'b1;
          st_waddr      = 1'b1;
          parm_stb_next = 1'b1;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ctl_reg      <= 3'h0;
      cmd_stb_reg  <= 1'b0;
      parm_stb_reg <= 1'b0;
    end else if (CE_I) begin
      ctl_reg      <= ctl_next;
      cmd_stb_reg  <= cmd_stb_next;
      parm_stb_reg <= parm_stb_next;
    end
  end

  // opcode words held in a small store; port A side reads parameter
  logic [15:0] st_rdata;
  vxd_opcode_store #(
    .WIDTH(16)
  ) u_store (
    .clk_i  (REF_CLK_I),
    .rst_b_i(RST_B_I),
    .ce_i   (CE_I),
    .we_i   (st_we),
    .waddr_i(st_waddr),
    .wdata_i(BUS_REQ_I.wdata),
    .wmask_i(lane_mask),
    .raddr_i(1'b1),
    .rdata_o(st_rdata)
  );

  // command value kept in a shadow register beside the store, not read from its port
  logic [15:0] cmd_reg;
  logic [15:0] cmd_next;
  always_comb begin
    cmd_next = cmd_reg;
    if (st_we && !st_waddr)
      cmd_next = (cmd_reg & ~lane_mask) | (BUS_REQ_I.wdata & lane_mask);
  end
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) cmd_reg <= vxd_pkg::CMD_RESET;
    else if (CE_I) cmd_reg <= cmd_next;
  end

  assign CONTROL_O     = ctl_reg;
  assign CMD_OPCODE_O  = cmd_reg;
  assign CMD_STROBE_O  = cmd_stb_reg;
  assign PARM_OPCODE_O = st_rdata;
  assign PARM_STROBE_O = parm_stb_reg;

  ////////////////////////////////////////////////////////////////////////
  // read side and acknowledge, one cycle after the strobe

  logic        ack_reg;
  logic        ack_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [15:0] rd_word;

  // read mux; the command offset reads back the query side input
  always_comb begin
    case (sel)
      vxd_pkg::VXD_SEL_ID:      rd_word = vxd_pkg::ID_VALUE;
      vxd_pkg::VXD_SEL_DEVTYPE: rd_word = vxd_pkg::DEVTYPE_VALUE;
      vxd_pkg::VXD_SEL_STATCTL: rd_word = {vxd_pkg::STAT_HI, STATUS_I[7:0]};
      vxd_pkg::VXD_SEL_CMD:     rd_word = STATUS_I;
      vxd_pkg::VXD_SEL_DATA:    rd_word = DATA_I;
      vxd_pkg::VXD_SEL_DATA_LO: rd_word = DATA_I;
      default:                  rd_word = 16'h0000;
    endcase
    ack_next   = hit;
    rdata_next = rdata_reg;
    if (hit && !BUS_REQ_I.write) begin
      // byte reads return the chosen lane in the low bits
      if (BUS_REQ_I.word) rdata_next = rd_word;
      else if (BUS_REQ_I.addr[0]) rdata_next = {8'h00, rd_word[7:0]};
      else rdata_next = {8'h00, rd_word[15:8]};
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 16'h0000;
    end else if (CE_I) begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign BUS_RSP_O = '{ack: ack_reg, rdata: rdata_reg};

  ////////////////////////////////////////////////////////////////////////
  // checks

  a_out_block_quiet: assert property (@(posedge REF_CLK_I)
    disable iff (!RST_B_I)
    (CE_I && BUS_REQ_I.strobe &&
     BUS_REQ_I.addr[15:6] != blk_base[15:6]) |=> !ack_reg)
    else $error("ack for foreign address");
  a_low_quarter: assert property (@(posedge REF_CLK_I)
    disable iff (!RST_B_I)
    (CE_I && BUS_REQ_I.addr[15:14] != 2'h3) |=> !ack_reg)
    else $error("ack below top quarter");
  a_hit_acks: assert property (@(posedge REF_CLK_I)
    disable iff (!RST_B_I)
    (CE_I && BUS_REQ_I.strobe &&
     BUS_REQ_I.addr[15:6] == ({2'h3, 14'h0000} >> 6) + la_reg &&
     offs_sel(BUS_REQ_I.addr[5:0]) != vxd_pkg::VXD_SEL_NONE) |=> ack_reg)
    else $error("claimed access not acknowledged");
  a_empty_offset: assert property (@(posedge REF_CLK_I)
    disable iff (!RST_B_I)
    (CE_I && BUS_REQ_I.addr[5:0] == 6'h10) |=> !ack_reg)
    else $error("ack for empty offset");
  a_cmd_write: assert property (@(posedge REF_CLK_I)
    disable iff (!RST_B_I)
    (CE_I && hit && BUS_REQ_I.write && BUS_REQ_I.word &&
     BUS_REQ_I.addr[5:0] == 6'h08) |=> (CMD_STROBE_O &&
     CMD_OPCODE_O == $past(BUS_REQ_I.wdata)))
    else $error("command write lost");
  a_byte_read: assert property (@(posedge REF_CLK_I)
    disable iff (!RST_B_I)
    (CE_I && hit && !BUS_REQ_I.write && !BUS_REQ_I.word) |=>
    (BUS_RSP_O.rdata[15:8] == 8'h00))
    else $error("byte read high lane not zero");
  a_la_default: assert property (@(posedge REF_CLK_I)
    disable iff (!RST_B_I)
    $rose(RST_B_I) |-> (la_reg == LA_DEFAULT))
    else $error("logical address not default");
  a_ack_one_cycle: assert property (@(posedge REF_CLK_I)
    disable iff (!RST_B_I)
    (CE_I && !BUS_REQ_I.strobe) |=> !ack_reg)
    else $error("ack without strobe");
  a_block_size: assert property (@(posedge REF_CLK_I)
    disable iff (!RST_B_I)
    (CE_I && BUS_REQ_I.strobe && BUS_REQ_I.addr[5:0] == 6'h08 &&
     BUS_REQ_I.addr[15:6] == blk_base[15:6] + 10'h001)
    |=> !ack_reg)
    else $error("neighbour block claimed");

  c_word_write: cover property (@(posedge REF_CLK_I)
    hit && BUS_REQ_I.write && BUS_REQ_I.word);
  c_byte_read: cover property (@(posedge REF_CLK_I)
    hit && !BUS_REQ_I.write && !BUS_REQ_I.word);
  c_miss: cover property (@(posedge REF_CLK_I)
    BUS_REQ_I.strobe && !hit);

endmodule : vxd_reg_window
`default_nettype wire

//--- testbench/vxd_ctrl_model.sv
// vxd_ctrl_model: backplane controller issuing byte and word accesses
// assumes one access at a time, driven 2 ns after the rising edge
`timescale 1ns/1ns
`default_nettype none
module vxd_ctrl_model (
  input  wire logic              clk_i,
  input  wire vxd_pkg::vxd_rsp_t rsp_i,
  output var  vxd_pkg::vxd_req_t req_o
);
  //////////////////////////////////////////////////////////////////////
  // idle bus at start
  initial begin
    req_o = '0;
  end

  // one access; the entry edge keeps two accesses from landing in one
  // time step, and released lines show inverted values, not stale ones
  task automatic access(input logic wr, input logic wd,
                        input logic [15:0] a, input logic [15:0] d,
                        output logic ack, output logic [15:0] rd);
    @(posedge clk_i);
    #2;
    req_o = '{strobe: 1'b1, write: wr, word: wd,
              addr: a, wdata: d};
    @(posedge clk_i);
    #2;
    ack = rsp_i.ack;
    rd = rsp_i.rdata;
    req_o.strobe = 1'b0;
    req_o.addr = ~a;
    req_o.wdata = ~d;
  endtask : access
endmodule : vxd_ctrl_model
`default_nettype wire

//--- testbench/tb_top.sv
// tb_top: self-checking bench for the register window decoder
// assumes the controller model and the decoder share one 20 MHz clock
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  logic              ce = 1'b1;
  logic              la_load = 1'b0;
  logic [7:0]        la_val = 8'h00;
  logic [15:0]       status = 16'h1234;
  logic [15:0]       data = 16'hBEEF;
  vxd_pkg::vxd_req_t req;
  vxd_pkg::vxd_rsp_t rsp;
  logic [2:0]        ctl;
  logic [15:0]       cmd;
  logic [15:0]       parm;
  logic              cstb;
  logic              pstb;
  logic [7:0]        la;
  logic              ack;
  logic [15:0]       rd;
  int                mismatches = 0;
  int                comparisons = 0;
  logic [5:0]        offs [7] = '{6'h00, 6'h02, 6'h04, 6'h08,
                                  6'h0A, 6'h0C, 6'h0E};
  logic [15:0]       want [7];

  //////////////////////////////////////////////////////////////////////
  // 50 ns clock
  always #25 clk = ~clk;

  vxd_reg_window i_vxd_reg_window (
    .REF_CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce), .LA_LOAD_I(la_load),
    .LA_VALUE_I(la_val), .BUS_REQ_I(req), .STATUS_I(status), .DATA_I(data),
    .BUS_RSP_O(rsp), .CONTROL_O(ctl), .CMD_OPCODE_O(cmd),
    .CMD_STROBE_O(cstb), .PARM_OPCODE_O(parm), .PARM_STROBE_O(pstb),
    .LA_O(la));

  vxd_ctrl_model i_vxd_ctrl_model (.clk_i(clk), .rsp_i(rsp), .req_o(req));

  //////////////////////////////////////////////////////////////////////
  // comparison and closing
  task automatic check(input string what, input logic [15:0] got,
                       input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  task automatic acc(input logic wr, input logic wd, input logic [15:0] a,
                     input logic [15:0] d);
    i_vxd_ctrl_model.access(wr, wd, a, d, ack, rd);
  endtask : acc

  // logical address stands in for the selection switch
  task automatic set_la(input logic [7:0] v);
    @(posedge clk);
    #2;
    la_load = 1'b1;
    la_val = v;
    @(posedge clk);
    #2;
    la_load = 1'b0;
    check("la", {8'h00, la}, {8'h00, v});
  endtask : set_la

  //////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    check("la rst", {8'h00, la}, 16'h0018);
    check("ack rst", {15'h0, rsp.ack}, 16'h0000);
    check("cmd rst", cmd, 16'h0000);
    check("ctl rst", {13'h0, ctl}, 16'h0000);
  endtask : t_reset

  task automatic t_command;
    acc(1'b1, 1'b1, 16'hC608, 16'h0004);
    check("cmd ack", {15'h0, ack}, 16'h0001);
    check("cmd", cmd, 16'h0004);
    check("cmd stb", {15'h0, cstb}, 16'h0001);
  endtask : t_command

  // every implemented offset answers; holes in the block stay silent
  task automatic t_offsets;
    logic [15:0] holes [4] = '{16'hC606, 16'hC610, 16'hC63E, 16'hC607};
    want = '{vxd_pkg::ID_VALUE, vxd_pkg::DEVTYPE_VALUE,
             {vxd_pkg::STAT_HI, status[7:0]}, status, 16'h0000, data, data};
    foreach (offs[i]) begin
      acc(1'b0, 1'b1, 16'hC600 + {10'h000, offs[i]}, 16'h0000);
      check("imp ack", {15'h0, ack}, 16'h0001);
      check("imp data", rd, want[i]);
    end
    foreach (holes[i]) begin
      acc(1'b0, holes[i][0] == 1'b0, holes[i], 16'h0000);
      check("hole ack", {15'h0, ack}, 16'h0000);
    end
  endtask : t_offsets

  task automatic t_outside;
    logic [15:0] outs [3] = '{16'h8608, 16'hC648, 16'h4608};
    foreach (outs[i]) begin
      acc(1'b1, 1'b1, outs[i], 16'h1111);
      check("out ack", {15'h0, ack}, 16'h0000);
      check("out stb", {15'h0, cstb}, 16'h0000);
      check("out cmd", cmd, 16'h0004);
    end
  endtask : t_outside

  // byte lanes: even is the high lane, odd the low lane
  task automatic t_bytes;
    acc(1'b0, 1'b0, 16'hC605, 16'h0000);
    check("rd lo", rd, {8'h00, status[7:0]});
    acc(1'b0, 1'b0, 16'hC604, 16'h0000);
    check("rd hi", rd, {8'h00, vxd_pkg::STAT_HI});
    acc(1'b1, 1'b0, 16'hC609, 16'h5A5A);
    check("wr lo", cmd, 16'h005A);
    acc(1'b1, 1'b0, 16'hC608, 16'hA5A5);
    check("wr hi", cmd, 16'hA55A);
    acc(1'b1, 1'b1, 16'hC604, 16'h0005);
    check("ctl", {13'h0, ctl}, 16'h0005);
    acc(1'b1, 1'b0, 16'hC604, 16'h0200);
    check("ctl even", {13'h0, ctl}, 16'h0005);
    acc(1'b1, 1'b1, 16'hC60A, 16'h0123);
    check("parm stb", {15'h0, pstb}, 16'h0001);
    @(posedge clk);
    #2;
    check("parm", parm, 16'h0123);
  endtask : t_bytes

  // moved block: old base refused, lowest and highest blocks work
  task automatic t_la;
    set_la(8'h00);
    acc(1'b1, 1'b1, 16'hC008, 16'h0007);
    check("la0 cmd", cmd, 16'h0007);
    acc(1'b1, 1'b1, 16'hC608, 16'h0009);
    check("old ack", {15'h0, ack}, 16'h0000);
    set_la(8'hFF);
    acc(1'b1, 1'b1, 16'hFFC8, 16'h000B);
    check("laff cmd", cmd, 16'h000B);
  endtask : t_la

  // clock enable low freezes state: an access in that window is lost
  task automatic t_freeze;
    @(posedge clk);
    #2;
    ce = 1'b0;
    acc(1'b1, 1'b1, 16'hFFC8, 16'h0077);
    check("ce ack", {15'h0, ack}, 16'h0000);
    check("ce cmd", cmd, 16'h000B);
    ce = 1'b1;
  endtask : t_freeze

  // reset in mid-run brings back the default block and clears state
  task automatic t_rereset;
    @(posedge clk);
    #2;
    rst_b = 1'b0;
    @(posedge clk);
    #2;
    check("la rerst", {8'h00, la}, 16'h0018);
    check("cmd rerst", cmd, 16'h0000);
    check("ctl rerst", {13'h0, ctl}, 16'h0000);
    rst_b = 1'b1;
    acc(1'b1, 1'b1, 16'hC608, 16'h0021);
    check("rerst ack", {15'h0, ack}, 16'h0001);
    check("rerst cmd", cmd, 16'h0021);
  endtask : t_rereset

  //////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    repeat (5) @(posedge clk);
    #2;
    t_reset();
    rst_b = 1'b1;
    t_command();
    t_offsets();
    t_outside();
    t_bytes();
    t_la();
    t_freeze();
    t_rereset();
    report_and_stop();
  end

  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
